/* sensor_ctrl_pkg.sv */
// shared constants, types and decode helpers for the sensor control block
package sensor_ctrl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] PATH_RESET_ADDR = 7'h68;
  localparam logic [6:0] MOTION_ADDR     = 7'h69;
  localparam logic [6:0] USER_ADDR       = 7'h6A;
  localparam logic [6:0] POWER_ADDR      = 7'h6B;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACCEL_RST_BIT  = 1;
  localparam int TEMP_RST_BIT   = 0;
  localparam int MW_ON_BIT      = 7;
  localparam int MW_MODE_BIT    = 6;
  localparam int QUEUE_ON_BIT   = 6;
  localparam int SPI_ONLY_BIT   = 4;
  localparam int QUEUE_RST_BIT  = 2;
  localparam int ALL_CLEAR_BIT  = 0;
  localparam int REINIT_BIT     = 7;
  localparam int SLEEP_BIT      = 6;
  localparam int CYCLE_BIT      = 5;
  localparam int GYRO_IDLE_BIT  = 4;
  localparam int THERMO_OFF_BIT = 3;
  localparam int ACCEL_SB_MSB   = 5;
  localparam int ACCEL_SB_LSB   = 3;

  // ----------------------------------------------------------------
  // stored-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MOTION_KEEP = 8'hC0;
  localparam logic [7:0] USER_KEEP   = 8'h50;
  localparam logic [7:0] POWER_KEEP  = 8'h7F;
  localparam logic [7:0] MOTION_RST  = 8'h00;
  localparam logic [7:0] USER_RST    = 8'h00;
  localparam logic [7:0] POWER_RST   = 8'h40;

  // ----------------------------------------------------------------
  // clock source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_OSC      = 3'h0;
  localparam logic [2:0] CLK_AUTO     = 3'h1;
  localparam logic [2:0] CLK_AUTO_MAX = 3'h5;
  localparam logic [2:0] CLK_STOP     = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 10;
  localparam int QUEUE_RST_NS = 50;
  localparam int REINIT_NS    = 500;
  localparam int BASE_TICK_US = 1000;
  localparam logic [2:0] QUEUE_RST_CYCLES = 3'((QUEUE_RST_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [2:0] REINIT_CYCLES    = 3'((REINIT_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam int BASE_TICK_CYCLES = BASE_TICK_US * SYS_CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_OSC, SRC_PLL, SRC_STOP} clk_src_t;
  typedef enum logic {ST_RUN, ST_REINIT} seq_state_t;

  typedef struct packed {
    logic            valid;
    logic [2:0][15:0] axis;
  } accel_sample_t;

  typedef struct packed {
    logic       accel_path_rst;
    logic       temp_path_rst;
    logic       gyro_path_rst;
    logic       sensor_regs_clear;
    logic       queue_rst;
    logic       queue_host_access;
    logic       i2c_target_off;
    logic       motion_detect_on;
    logic       chip_reinit;
    logic       sleep;
    logic       accel_sample_req;
    logic [2:0] accel_axis_on;
    logic       gyro_sense_off;
    logic       gyro_drive_on;
    logic       thermometer_off;
    logic       use_pll;
    logic       clock_stopped;
    logic       timing_gen_rst;
  } ctrl_t;

  // clock source code to selected source
  function automatic clk_src_t decode_clk(input logic [2:0] code, input logic pll_ok);
    clk_src_t r;
    r = SRC_OSC;
    if (code == CLK_STOP) begin
      r = SRC_STOP;
    end else if (code >= CLK_AUTO && code <= CLK_AUTO_MAX && pll_ok) begin
      r = SRC_PLL;
    end
    return r;
  endfunction

endpackage

/* wake_rate_divider.sv */
// wake pacing divider for duty-cycled accelerometer sampling
`timescale 1ns/1ps
`default_nettype none
module wake_rate_divider
  import sensor_ctrl_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_TICK_CYCLES
)(
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       enable_in,
  input  wire logic [7:0] divider_in,
  output logic            tick_out
);
  localparam int BW = $clog2(BASE_CYCLES + 1);

  typedef struct packed {
    logic [BW-1:0] base_cnt;
    logic [7:0]    rate_cnt;
    logic          tick;
  } div_state_t;

  div_state_t s;
  div_state_t n;

  // base tick, then divide by divider+1; counters park while off
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!enable_in) begin
      n.base_cnt = '0;
      n.rate_cnt = '0;
    end else if (s.base_cnt == BW'(BASE_CYCLES - 1)) begin
      n.base_cnt = '0;
      if (s.rate_cnt >= divider_in) begin
        n.rate_cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.rate_cnt = s.rate_cnt + 8'h01;
      end
    end else begin
      n.base_cnt = s.base_cnt + BW'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_out = s.tick;
endmodule
`default_nettype wire

/* motion_compare.sv */
// sample-to-sample motion comparison per accelerometer axis
`timescale 1ns/1ps
`default_nettype none
module motion_compare
  import sensor_ctrl_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          srst_in,
  input  wire logic          enable_in,
  input  wire logic          clear_in,
  input  wire logic [2:0]    axis_on_in,
  input  wire accel_sample_t sample_in,
  input  wire logic [7:0]    threshold_in,
  output logic [2:0]         hit_out
);
  typedef struct packed {
    logic [2:0][15:0] prev;
    logic             have_prev;
    logic [2:0]       hit;
  } cmp_state_t;

  cmp_state_t       s;
  cmp_state_t       n;
  logic [2:0][16:0] diff;
  logic [2:0][16:0] mag;
  logic [2:0]       exceed;

  // signed difference, magnitude against threshold, per axis
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign diff[a]   = {sample_in.axis[a][15], sample_in.axis[a]} - {s.prev[a][15], s.prev[a]};
    assign mag[a]    = diff[a][16] ? 17'(-diff[a]) : diff[a];
    assign exceed[a] = axis_on_in[a] && (mag[a] > {9'h000, threshold_in});
  end

  // first sample after enable or clear only primes the history
  always_comb begin
    n = s;
    n.hit = 3'h0;
    if (clear_in || !enable_in) begin
      n.have_prev = 1'b0;
    end else if (sample_in.valid) begin
      n.prev = sample_in.axis;
      n.have_prev = 1'b1;
      if (s.have_prev) begin
        n.hit = exceed;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hit_out = s.hit;
endmodule
`default_nettype wire

/* sensor_reset_power_control.sv */
// reset, power and clock-source control registers of the motion sensor
// Overview of operation
// R1 - accel path reset bit resets accel path only, results kept
// R2 - temp path reset bit resets temp path only, results kept
// R3 - motion detection runs only while motion wake enable is one
// R4 - compare mode one compares each sample with the previous; zero unused
// R5 - queue bit enables queue; cleared blocks host queue access
// R6 - spi-only bit disables the i2c target module
// R7 - queue reset bit pulses queue reset, clears after one 10 MHz cycle
// R8 - all-paths bit resets gyro, accel, temp paths and clears results
// R9 - reinit bit restores register defaults, clears itself when done
// R10 - sleep bit sleeps the chip; resets to one
// R11 - cycle mode alternates sleep and single accel samples at divider rate
// R12 - cycle mode with all accel axes standby wakes but takes no sample
// R13 - gyro idle keeps drive and pll running, sense paths off
// R14 - thermometer off bit disables temperature sensor
// R15 - clock source resets to code zero, internal oscillator
// R16 - code one selects pll when ready, otherwise oscillator
// R17 - code seven stops the clock and holds timing generator reset
// R18 - each accel axis disabled while its standby bit is one
// R19 - motion events set three-bit status field, cleared by status read
// R20 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module sensor_reset_power_control
  import sensor_ctrl_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_TICK_CYCLES
)(
  input  wire logic          clk_sys_in,
  input  wire logic          srst_in,
  input  wire logic [6:0]    reg_addr_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [7:0]    reg_wdata_in,
  output logic [7:0]         reg_rdata_out,
  input  wire logic [7:0]    sample_divider_in,
  input  wire logic [5:0]    axis_standby_in,
  input  wire logic          pll_ready_in,
  input  wire accel_sample_t accel_sample_in,
  input  wire logic [7:0]    motion_threshold_in,
  input  wire logic          status_read_in,
  output ctrl_t              ctrl_out,
  output logic [2:0]         motion_wake_flags_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t seq;
    logic [2:0] reinit_cnt;
    logic [2:0] queue_cnt;
    logic [7:0] motion;
    logic [7:0] user;
    logic [7:0] power;
    logic [1:0] path_pulse;
    logic       all_clear;
    logic [7:0] rdata;
    logic [2:0] flags;
    logic       pll_meta;
    logic       pll_sync;
    ctrl_t      ctrl;
  } top_state_t;

  top_state_t s;
  top_state_t n;
  logic       wake_tick;
  logic [2:0] motion_hit;
  logic       cycle_now;
  logic       sub_rst;
  logic       wr_ok;
  clk_src_t   src;

  // writes are refused while the chip reinitialises
  assign wr_ok     = reg_wr_in && (s.seq == ST_RUN);
  assign cycle_now = s.power[CYCLE_BIT] && !s.power[SLEEP_BIT] && !s.power[GYRO_IDLE_BIT];
  assign sub_rst   = srst_in || s.ctrl.chip_reinit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wake_rate_divider #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_wake (
    .clk_sys_in (clk_sys_in),
    .srst_in    (sub_rst),
    .enable_in  (cycle_now),
    .divider_in (sample_divider_in),
    .tick_out   (wake_tick)
  );

  motion_compare u_motion (
    .clk_sys_in   (clk_sys_in),
    .srst_in      (sub_rst),
    .enable_in    (s.ctrl.motion_detect_on),
    .clear_in     (s.ctrl.accel_path_rst),
    .axis_on_in   (s.ctrl.accel_axis_on),
    .sample_in    (accel_sample_in),
    .threshold_in (motion_threshold_in),
    .hit_out      (motion_hit)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // pll ready comes from the analog side, so two flops first
    n.pll_meta = pll_ready_in;
    n.pll_sync = s.pll_meta;
    n.path_pulse = 2'b00;
    n.all_clear = 1'b0;
    if (s.queue_cnt != 3'h0) begin
      n.queue_cnt = s.queue_cnt - 3'h1;
    end
    unique case (s.seq)
      ST_RUN: begin
        // R9 reinit start
        if (wr_ok && reg_addr_in == POWER_ADDR && reg_wdata_in[REINIT_BIT]) begin
          n.seq = ST_REINIT;
          n.reinit_cnt = REINIT_CYCLES;
        end else if (wr_ok) begin
          // R20 reserved bits dropped
          case (reg_addr_in)
            PATH_RESET_ADDR: begin
              n.path_pulse = {reg_wdata_in[ACCEL_RST_BIT], reg_wdata_in[TEMP_RST_BIT]};
            end
            MOTION_ADDR: begin
              n.motion = reg_wdata_in & MOTION_KEEP;
            end
            USER_ADDR: begin
              n.user = reg_wdata_in & USER_KEEP;
              // R7 queue reset pulse
              if (reg_wdata_in[QUEUE_RST_BIT]) begin
                n.queue_cnt = QUEUE_RST_CYCLES;
              end
              n.all_clear = reg_wdata_in[ALL_CLEAR_BIT];
            end
            POWER_ADDR: begin
              n.power = reg_wdata_in & POWER_KEEP;
            end
            default: ;
          endcase
        end
      end
      ST_REINIT: begin
        n.reinit_cnt = s.reinit_cnt - 3'h1;
        if (s.reinit_cnt == 3'h1) begin
          n.seq = ST_RUN;
        end
      end
    endcase
    // R9 defaults held during reinit
    if (n.seq == ST_REINIT) begin
      n.motion = MOTION_RST;
      n.user = USER_RST;
      n.power = POWER_RST;
      n.queue_cnt = 3'h0;
      n.flags = 3'h0;
    end else begin
      // R19 set wins over read clear
      n.flags = (s.flags & {3{!status_read_in}}) | motion_hit;
    end

    // register read port, reserved bits read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        MOTION_ADDR: n.rdata = s.motion;
        USER_ADDR:   n.rdata = s.user | {5'h00, s.queue_cnt != 3'h0, 1'b0, s.all_clear};
        POWER_ADDR:  n.rdata = s.power | {s.seq == ST_REINIT, 7'h00};
        default:     n.rdata = 8'h00;
      endcase
    end

    // R1 R2 R8 path resets
    n.ctrl.accel_path_rst = n.path_pulse[1] || n.all_clear;
    n.ctrl.temp_path_rst = n.path_pulse[0] || n.all_clear;
    n.ctrl.gyro_path_rst = n.all_clear;
    n.ctrl.sensor_regs_clear = n.all_clear;
    // R7 queue reset level
    n.ctrl.queue_rst = n.queue_cnt != 3'h0;
    // R5 host queue access
    n.ctrl.queue_host_access = n.user[QUEUE_ON_BIT];
    // R6 spi only
    n.ctrl.i2c_target_off = n.user[SPI_ONLY_BIT];
    // R3 R4 compare needs both bits
    n.ctrl.motion_detect_on = n.motion[MW_ON_BIT] && n.motion[MW_MODE_BIT];
    n.ctrl.chip_reinit = n.seq == ST_REINIT;
    // R10 R11 duty cycling wakes only on tick
    n.ctrl.sleep = n.power[SLEEP_BIT] || (cycle_now && !wake_tick);
    // R12 wake without sample
    // a sleep write landing on the tick cycle wins over the pending sample
    n.ctrl.accel_sample_req = cycle_now && wake_tick && !n.power[SLEEP_BIT]
                              && !(&axis_standby_in[ACCEL_SB_MSB:ACCEL_SB_LSB]);
    // R18 axis standby
    n.ctrl.accel_axis_on = ~axis_standby_in[ACCEL_SB_MSB:ACCEL_SB_LSB];
    // R13 gyro idle
    n.ctrl.gyro_sense_off = n.power[GYRO_IDLE_BIT] || n.power[SLEEP_BIT];
    n.ctrl.gyro_drive_on = !n.power[SLEEP_BIT];
    // R14 thermometer
    n.ctrl.thermometer_off = n.power[THERMO_OFF_BIT];
    // R15 R16 R17 clock source
    src = decode_clk(n.power[2:0], s.pll_sync);
    n.ctrl.use_pll = src == SRC_PLL;
    n.ctrl.clock_stopped = src == SRC_STOP;
    n.ctrl.timing_gen_rst = src == SRC_STOP;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset image: defaults, sleeping, oscillator selected
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s <= '0;
      s.seq <= ST_RUN;
      s.motion <= MOTION_RST;
      s.user <= USER_RST;
      s.power <= POWER_RST;
      s.ctrl.sleep <= 1'b1;
      s.ctrl.gyro_sense_off <= 1'b1;
      s.ctrl.accel_axis_on <= 3'h7;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign ctrl_out = s.ctrl;
  assign motion_wake_flags_out = s.flags;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  logic wr_path;
  logic wr_user;
  logic wr_power;
  assign wr_path  = wr_ok && reg_addr_in == PATH_RESET_ADDR;
  assign wr_user  = wr_ok && reg_addr_in == USER_ADDR;
  assign wr_power = wr_ok && reg_addr_in == POWER_ADDR;

  sequence s_reinit_busy;
    ctrl_out.chip_reinit [*5] ##1 !ctrl_out.chip_reinit;
  endsequence
  sequence s_queue_pulse;
    ctrl_out.queue_rst ##1 !ctrl_out.queue_rst;
  endsequence

  property p_accel_rst;
    wr_path && reg_wdata_in[ACCEL_RST_BIT] |=> ctrl_out.accel_path_rst
      && !ctrl_out.sensor_regs_clear && !ctrl_out.gyro_path_rst;
  endproperty
  a_accel_rst: assert property (p_accel_rst) else $error("accel path reset wrong"); // R1

  property p_temp_rst;
    wr_path && reg_wdata_in[TEMP_RST_BIT] |=> ctrl_out.temp_path_rst && !ctrl_out.sensor_regs_clear;
  endproperty
  a_temp_rst: assert property (p_temp_rst) else $error("temp path reset wrong"); // R2

  property p_all_clear;
    wr_user && reg_wdata_in[ALL_CLEAR_BIT] |=> ctrl_out.accel_path_rst && ctrl_out.temp_path_rst
      && ctrl_out.gyro_path_rst && ctrl_out.sensor_regs_clear;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("all path reset wrong"); // R8

  property p_queue_rst;
    (wr_user && reg_wdata_in[QUEUE_RST_BIT]) ##1 !(wr_user && reg_wdata_in[QUEUE_RST_BIT])
      |-> s_queue_pulse;
  endproperty
  a_queue_rst: assert property (p_queue_rst) else $error("queue reset not one cycle"); // R7

  property p_reinit;
    wr_power && reg_wdata_in[REINIT_BIT] |=> s_reinit_busy ##0 ctrl_out.sleep;
  endproperty
  a_reinit: assert property (p_reinit) else $error("reinit length or defaults wrong"); // R9

  property p_spi_only;
    wr_user |=> ctrl_out.i2c_target_off == $past(reg_wdata_in[SPI_ONLY_BIT]);
  endproperty
  a_spi_only: assert property (p_spi_only) else $error("spi only select wrong"); // R6

  property p_sleep_bit;
    s.power[SLEEP_BIT] |-> ctrl_out.sleep && !ctrl_out.accel_sample_req;
  endproperty
  a_sleep_bit: assert property (p_sleep_bit) else $error("sleep bit ignored"); // R10

  property p_cycle_sample;
    ctrl_out.accel_sample_req |-> !ctrl_out.sleep && $past(!(&axis_standby_in[5:3]));
  endproperty
  a_cycle_sample: assert property (p_cycle_sample) else $error("sample while asleep or all standby"); // R11 R12

  property p_clk_stop;
    s.power[2:0] == CLK_STOP |-> ctrl_out.clock_stopped && ctrl_out.timing_gen_rst && !ctrl_out.use_pll;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("stop code not honoured"); // R17

  property p_clk_auto;
    s.power[2:0] == CLK_AUTO |-> ctrl_out.use_pll == $past(s.pll_sync);
  endproperty
  a_clk_auto: assert property (p_clk_auto) else $error("auto clock select wrong"); // R16

  property p_flags;
    |motion_hit |=> (motion_wake_flags_out & $past(motion_hit)) == $past(motion_hit);
  endproperty
  a_flags: assert property (p_flags) else $error("motion event lost"); // R19

  property p_reserved;
    reg_rd_in && reg_addr_in == MOTION_ADDR |=> reg_rdata_out[5:0] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R20

endmodule
`default_nettype wire

/* sensor_host_model.sv */
// host-side register access model for the sensor control block
`timescale 1ns/1ps
`default_nettype none
module sensor_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic [6:0]      addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out
);
  // ----------------------------------------------------------------
  // register bus cycles
  // ----------------------------------------------------------------
  // idle state; address is a level so it simply stays put
  initial begin
    addr_out  = 7'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // host writes whole bytes, one strobe cycle each
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // stale data is inverted so a late sample cannot pass by luck
    wdata_out <= ~d;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

/* tb_sensor_reset_power_control.sv */
// self-checking testbench for the sensor reset and power control block
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_reset_power_control;
  import sensor_ctrl_pkg::*;
  localparam int BASE = 4;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic [6:0]    addr;
  logic          wr_en;
  logic          rd_en;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic [7:0]    divider = 8'h00;
  logic [7:0]    thresh = 8'h10;
  logic [5:0]    standby = 6'h00;
  logic          pll_rdy = 1'b0;
  logic          stat_rd = 1'b0;
  accel_sample_t smp = '0;
  ctrl_t         ctrl;
  logic [2:0]    flags;
  logic [7:0]    d;
  int            n;
  int            err_total = 0;
  int            comparisons = 0;
  int            cycles = 0;

  always #50 clk = ~clk;

  sensor_reset_power_control #(.BASE_CYCLES(BASE)) u_sensor_reset_power_control (
    .clk_sys_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wr_in(wr_en),
    .reg_rd_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .sample_divider_in(divider), .axis_standby_in(standby), .pll_ready_in(pll_rdy),
    .accel_sample_in(smp), .motion_threshold_in(thresh), .status_read_in(stat_rd),
    .ctrl_out(ctrl), .motion_wake_flags_out(flags));

  sensor_host_model u_sensor_host_model (
    .clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr_en),
    .rd_out(rd_en), .wdata_out(wdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string what);
    u_sensor_host_model.rd(a, d);
    chk(d, exp, what);
  endtask

  // one valid sample with the same value on every axis
  task automatic send(input logic [15:0] v);
    @(posedge clk);
    smp.valid <= 1'b1;
    smp.axis  <= {3{v}};
    @(posedge clk);
    smp.valid <= 1'b0;
  endtask

  // bounded wait for the next wake, returns cycles waited
  task automatic wake(output int k);
    k = 0;
    do begin
      tick();
      k++;
    end while (ctrl.sleep !== 1'b0 && k < 40);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdchk(PATH_RESET_ADDR, 8'h00, "path reg");
    rdchk(MOTION_ADDR, 8'h00, "motion reset");
    rdchk(POWER_ADDR, 8'h40, "power reset");
    rdchk(7'h70, 8'h00, "unmapped");
    chk({ctrl.sleep, ctrl.use_pll, ctrl.clock_stopped, ctrl.gyro_drive_on,
         ctrl.gyro_sense_off}, 8'h11, "reset ctrl");
    $display("test reset done");
    u_sensor_host_model.wr(PATH_RESET_ADDR, 8'h03);
    #1;
    chk({ctrl.accel_path_rst, ctrl.temp_path_rst, ctrl.gyro_path_rst,
         ctrl.sensor_regs_clear}, 8'h0C, "path pulse");
    tick();
    chk({ctrl.accel_path_rst, ctrl.temp_path_rst}, 8'h00, "path end");
    u_sensor_host_model.wr(USER_ADDR, 8'hFF);
    #1;
    chk({ctrl.queue_rst, ctrl.gyro_path_rst, ctrl.accel_path_rst, ctrl.temp_path_rst,
         ctrl.sensor_regs_clear}, 8'h1F, "all clear");
    tick();
    chk({ctrl.queue_rst, ctrl.sensor_regs_clear, ctrl.queue_host_access,
         ctrl.i2c_target_off}, 8'h03, "user lvl");
    rdchk(USER_ADDR, 8'h50, "user rb");
    u_sensor_host_model.wr(USER_ADDR, 8'h00);
    #1;
    chk({ctrl.queue_host_access, ctrl.i2c_target_off}, 8'h00, "user off");
    $display("test paths done");
    // clock source codes with the pll ready
    @(posedge clk);
    pll_rdy <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      u_sensor_host_model.wr(POWER_ADDR, {5'b00011, 3'(c)});
      #1;
      chk({ctrl.use_pll, ctrl.clock_stopped, ctrl.timing_gen_rst},
          {5'b0, (c >= 1 && c <= 5), {2{c == 7}}}, "clk src");
      rdchk(POWER_ADDR, {5'b00011, 3'(c)}, "power rb");
    end
    chk({ctrl.gyro_sense_off, ctrl.gyro_drive_on, ctrl.thermometer_off}, 8'h07, "idle");
    @(posedge clk);
    pll_rdy <= 1'b0;
    u_sensor_host_model.wr(POWER_ADDR, 8'h01);
    repeat (3) tick();
    chk(ctrl.use_pll, 8'h00, "no pll");
    u_sensor_host_model.wr(POWER_ADDR, 8'h00);
    #1;
    chk({ctrl.gyro_sense_off, ctrl.thermometer_off}, 8'h00, "awake");
    $display("test clock done");
    u_sensor_host_model.wr(MOTION_ADDR, 8'hFF);
    #1;
    chk(ctrl.motion_detect_on, 8'h01, "wake on");
    rdchk(MOTION_ADDR, 8'hC0, "motion rb");
    send(16'h0000);
    send(16'h0100);
    repeat (4) tick();
    chk(flags, 8'h07, "flags set");
    @(posedge clk);
    stat_rd <= 1'b1;
    @(posedge clk);
    stat_rd <= 1'b0;
    repeat (3) tick();
    chk(flags, 8'h00, "flags clr");
    u_sensor_host_model.wr(MOTION_ADDR, 8'h40);
    #1;
    chk(ctrl.motion_detect_on, 8'h00, "wake off");
    send(16'h0000);
    repeat (4) tick();
    chk(flags, 8'h00, "no detect");
    $display("test motion done");
    // duty cycling, period (div+1)*BASE
    u_sensor_host_model.wr(POWER_ADDR, 8'h20);
    wake(n);
    chk(ctrl.accel_sample_req, 8'h01, "sample");
    wake(n);
    chk(8'(n), 8'(BASE), "period");
    @(posedge clk);
    divider <= 8'h01;
    standby <= 6'b111000;
    wake(n);
    chk(ctrl.accel_sample_req, 8'h00, "no sample");
    wake(n);
    chk(8'(n), 8'(2 * BASE), "period sb");
    @(posedge clk);
    standby <= 6'b101000;
    repeat (2) tick();
    chk(ctrl.accel_axis_on, 8'h02, "axis on");
    @(posedge clk);
    standby <= 6'h00;
    $display("test cycle done");
    u_sensor_host_model.wr(MOTION_ADDR, 8'hC0);
    u_sensor_host_model.wr(POWER_ADDR, 8'h80);
    #1;
    chk(ctrl.chip_reinit, 8'h01, "reinit on");
    repeat (4) tick();
    chk(ctrl.chip_reinit, 8'h01, "reinit c5");
    tick();
    chk(ctrl.chip_reinit, 8'h00, "reinit end");
    rdchk(POWER_ADDR, 8'h40, "reinit pw");
    rdchk(MOTION_ADDR, 8'h00, "reinit mw");
    $display("test reinit done");
    give_verdict();
  end
endmodule
`default_nettype wire
